/* design/asmc_pkg.sv */
// Package of constants and types for the asynchronous static memory host controller
// Contract
// R1 - Memory holds 512K bytes, 19-bit address
// R2 - Four one-megabit banks, decoder on upper bits
// R3 - Device is asynchronous, no clock or refresh
// R4 - Write strobe stays high during reads
// R5 - Address valid before chip select falls
// R6 - Address changes only with strobe or select high
// R7 - Write happens during select and strobe overlap
// R8 - Write recovery timed from first strobe rising
// R9 - Host never drives while device drives
// R10 - Select after strobe keeps outputs floating
// R11 - Gate low write pulse covers float plus overlap
// R12 - Gate high write may use minimum pulse
// R13 - Read data valid within gate access time
// R14 - Deselect floats outputs within deselect time
// R15 - Deselect enters standby within powerdown time
// R16 - After reset hold select and strobe high
`default_nettype none
package asmc_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int ADDR_WIDTH = 19; // 512K words
    localparam int DATA_WIDTH = 8; // Byte wide

    // ----------------------------------------------------------------
    // Timing in ns, fastest grade, and derived cycle counts at 100 MHz
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CYCLE_TIME_NS = 25; // Read and write cycle time
    localparam int WRITE_PULSE_NS = 17; // Minimum write pulse
    localparam int DATA_OVERLAP_NS = 15; // Data to end of write
    localparam int WRITE_TO_FLOAT_TIME_NS = 15;
    localparam int GATE_ACCESS_TIME_NS = 12;
    localparam int DESELECT_FLOAT_TIME_NS = 14;
    localparam int POWERDOWN_TIME_NS = 25;
    localparam int ADDR_SETUP_NS = 3;
    localparam int DATA_HOLD_NS = 3; // Covers select-controlled variant

    // Least times round up
    localparam int CYCLE_CYCLES = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_GATE_HIGH_CYCLES = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_GATE_LOW_NS = (WRITE_TO_FLOAT_TIME_NS + DATA_OVERLAP_NS > WRITE_PULSE_NS) ?
        WRITE_TO_FLOAT_TIME_NS + DATA_OVERLAP_NS : WRITE_PULSE_NS;
    localparam int PULSE_GATE_LOW_CYCLES = (PULSE_GATE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOAT_CYCLES = (WRITE_TO_FLOAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_ACCESS_CYCLES = (GATE_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DESELECT_CYCLES = (DESELECT_FLOAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYCLES = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYCLES = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COUNT_WIDTH = 4;

    // ----------------------------------------------------------------
    // Reset values of the pins
    // ----------------------------------------------------------------
    localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 19'h0_0000;
    localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, // Deselected, standby
        ST_SETUP = 3'b001, // Address settling, strobes high
        ST_READ = 3'b010, // Select and gate low, waiting for data
        ST_WRITE = 3'b011, // Select and strobe low
        ST_HOLD = 3'b100, // Strobe high, data held
        ST_RECOVER = 3'b101 // Deselected, finishing the cycle time
    } asmc_state_type;

    typedef struct packed {
        asmc_state_type state;
        logic [COUNT_WIDTH-1:0] count;
        logic [COUNT_WIDTH-1:0] cycle_count;
        logic is_write;
        logic gate_low_write;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
        logic [DATA_WIDTH-1:0] rdata;
        logic rvalid;
        logic wdone;
        logic chip_sel_n;
        logic write_strobe_n;
        logic out_gate_n;
        logic data_oe;
    } asmc_regs_type;

endpackage
`default_nettype wire

/* design/asmc_host.sv */
// Host controller driving an asynchronous 512K x 8 static memory through its pins
`timescale 1ns/10ps
`default_nettype none
module asmc_host (
    input wire logic clk_sys_in, // 100 MHz system clock
    input wire logic reset_in, // Asynchronous, active high
    // User request side
    input wire logic req_valid_in, // Request present
    input wire logic req_write_in, // 1 write, 0 read
    input wire logic req_gate_low_in, // Keep output gate low during write
    input wire logic [asmc_pkg::ADDR_WIDTH-1:0] req_addr_in, // Word address
    input wire logic [asmc_pkg::DATA_WIDTH-1:0] req_wdata_in, // Write data
    output logic req_ready_out, // Request taken when valid and ready
    output logic [asmc_pkg::DATA_WIDTH-1:0] rdata_out, // Read data
    output logic rdata_valid_out, // One-cycle pulse with read data
    output logic wdone_out, // One-cycle pulse at end of write
    // Memory pins
    output logic [asmc_pkg::ADDR_WIDTH-1:0] mem_addr_out, // Address lines
    output logic mem_chip_sel_n_out, // Chip select, active low
    output logic mem_write_strobe_n_out, // Write strobe, active low
    output logic mem_out_gate_n_out, // Output gate, active low
    output logic [asmc_pkg::DATA_WIDTH-1:0] mem_data_out, // Data driven to memory
    output logic mem_data_oe_out, // High while host drives the data pins
    input wire logic [asmc_pkg::DATA_WIDTH-1:0] mem_data_in // Data pins as seen
);

    // ----------------------------------------------------------------
    // State and synchroniser
    // ----------------------------------------------------------------
    asmc_pkg::asmc_regs_type regs; // All registered state except the two sync flops
    asmc_pkg::asmc_regs_type next_regs; // Next value
    logic [asmc_pkg::DATA_WIDTH-1:0] data_meta; // First sync stage, read only by data_sync
    logic [asmc_pkg::DATA_WIDTH-1:0] data_sync; // Second sync stage

    // Read data comes from outside the clock domain, so two flops first
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            data_meta <= asmc_pkg::DATA_RESET;
            data_sync <= asmc_pkg::DATA_RESET;
        end else begin
            data_meta <= mem_data_in;
            data_sync <= data_meta;
        end
    end

    // Count saturating helper, used for both counters
    function automatic logic [asmc_pkg::COUNT_WIDTH-1:0] count_up(input logic [asmc_pkg::COUNT_WIDTH-1:0] value);
        count_up = (value == 4'hF) ? value : value + 4'h1;
    endfunction

    // ----------------------------------------------------------------
    // Access sequence, counted in clock edges from the taking edge
    // ----------------------------------------------------------------
    // Every access starts the same way: the request is taken in idle,
    // address and write data are latched, and one setup edge passes with
    // select, strobe and gate all high, so the address settles first.
    //
    // Read:
    //   edge 1  select and gate fall together, strobe stays high
    //   edge 2+ the memory drives after its gate access time
    //   edge 6  the byte seen two flops late is captured, valid pulses,
    //           select and gate rise together
    //   Sampling waits out the full cycle time plus the two sync flops,
    //   so a slower grade only needs a larger cycle count.
    //
    // Write:
    //   edge 1  select and strobe fall together; the memory outputs stay
    //           floating, so the gate setting cannot cause contention
    //   gate high: data is driven from edge 2, strobe rises at edge 3
    //   gate low:  data waits for the float time, driven from edge 3,
    //              and the pulse is stretched, strobe rises at edge 4
    //   The gate rises with the strobe, because a selected memory with
    //   strobe high and gate low would start driving into the host.
    //   One hold edge later data is released, select rises, done pulses.
    //
    // Recovery:
    //   Select stays high for the deselect float time and until the cycle
    //   counter, started when select fell, covers the cycle time. Only
    //   then does ready return, so back-to-back accesses are spaced.
    //
    // Limitation: one access at a time, no pipelining; a request seen
    // while busy is simply not taken and must be held by the requester.

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_regs = regs;
        next_regs.rvalid = 1'b0;
        next_regs.wdone = 1'b0;
        next_regs.count = count_up(regs.count);
        next_regs.cycle_count = count_up(regs.cycle_count);
        unique case (regs.state)
            asmc_pkg::ST_IDLE: begin
                // Deselected: standby, outputs floating, strobe high
                next_regs.chip_sel_n = 1'b1; // R15
                next_regs.write_strobe_n = 1'b1; // R16
                next_regs.out_gate_n = 1'b1;
                next_regs.data_oe = 1'b0;
                if (req_valid_in) begin
                    // Address changes only while select and strobe are high
                    next_regs.addr = req_addr_in; // R6
                    next_regs.wdata = req_wdata_in;
                    next_regs.is_write = req_write_in;
                    next_regs.gate_low_write = req_gate_low_in;
                    next_regs.count = 4'h0;
                    next_regs.state = asmc_pkg::ST_SETUP;
                end
            end
            asmc_pkg::ST_SETUP: begin
                // Address is stable before select falls
                if (regs.count >= 4'(asmc_pkg::SETUP_CYCLES - 1)) begin // R5
                    next_regs.count = 4'h0;
                    next_regs.cycle_count = 4'h0;
                    next_regs.chip_sel_n = 1'b0;
                    if (regs.is_write) begin
                        // Strobe falls with select, so device outputs never turn on
                        next_regs.write_strobe_n = 1'b0; // R10
                        next_regs.out_gate_n = !regs.gate_low_write;
                        next_regs.state = asmc_pkg::ST_WRITE;
                    end else begin
                        next_regs.write_strobe_n = 1'b1; // R4
                        next_regs.out_gate_n = 1'b0; // R13
                        next_regs.state = asmc_pkg::ST_READ;
                    end
                end
            end
            asmc_pkg::ST_READ: begin
                // Wait for full access, which covers the gate access time too
                if (regs.count >= 4'(asmc_pkg::CYCLE_CYCLES + 1)) begin // R13
                    next_regs.rdata = data_sync;
                    next_regs.rvalid = 1'b1;
                    next_regs.chip_sel_n = 1'b1;
                    next_regs.out_gate_n = 1'b1;
                    next_regs.count = 4'h0;
                    next_regs.state = asmc_pkg::ST_RECOVER;
                end
            end
            asmc_pkg::ST_WRITE: begin
                // With gate low, hold data off until the device outputs float
                if (regs.gate_low_write && regs.count >= 4'(asmc_pkg::FLOAT_CYCLES - 1)) begin // R9
                    next_regs.data_oe = 1'b1;
                end else if (!regs.gate_low_write) begin
                    next_regs.data_oe = 1'b1;
                end
                if ((regs.gate_low_write && regs.count >= 4'(asmc_pkg::PULSE_GATE_LOW_CYCLES - 1)) || // R11
                    (!regs.gate_low_write && regs.count >= 4'(asmc_pkg::PULSE_GATE_HIGH_CYCLES - 1))) begin // R12
                    // Strobe rises first, ending the overlap; recovery timed from here
                    next_regs.write_strobe_n = 1'b1; // R7 R8
                    // Gate rises with the strobe: a selected memory would drive while host data still stands
                    next_regs.out_gate_n = 1'b1; // R9
                    next_regs.count = 4'h0;
                    next_regs.state = asmc_pkg::ST_HOLD;
                end
            end
            asmc_pkg::ST_HOLD: begin
                // Keep data driven past the strobe edge, then deselect
                if (regs.count >= 4'(asmc_pkg::HOLD_CYCLES - 1)) begin
                    next_regs.data_oe = 1'b0;
                    next_regs.chip_sel_n = 1'b1;
                    next_regs.out_gate_n = 1'b1;
                    next_regs.wdone = 1'b1;
                    next_regs.count = 4'h0;
                    next_regs.state = asmc_pkg::ST_RECOVER;
                end
            end
            asmc_pkg::ST_RECOVER: begin
                // Let the device float and finish the cycle time before next access
                if (regs.count >= 4'(asmc_pkg::DESELECT_CYCLES - 1) && // R14
                    regs.cycle_count >= 4'(asmc_pkg::CYCLE_CYCLES)) begin // R8
                    next_regs.state = asmc_pkg::ST_IDLE;
                end
            end
            default: begin
                // Illegal code: return to a safe, deselected idle
                next_regs.state = asmc_pkg::ST_IDLE;
                next_regs.chip_sel_n = 1'b1;
                next_regs.write_strobe_n = 1'b1;
                next_regs.data_oe = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            regs.state <= asmc_pkg::ST_IDLE;
            regs.count <= 4'h0;
            regs.cycle_count <= 4'h0;
            regs.is_write <= 1'b0;
            regs.gate_low_write <= 1'b0;
            regs.addr <= asmc_pkg::ADDR_RESET;
            regs.wdata <= asmc_pkg::DATA_RESET;
            regs.rdata <= asmc_pkg::DATA_RESET;
            regs.rvalid <= 1'b0;
            regs.wdone <= 1'b0;
            regs.chip_sel_n <= 1'b1; // R16
            regs.write_strobe_n <= 1'b1; // R16
            regs.out_gate_n <= 1'b1;
            regs.data_oe <= 1'b0;
        end else begin
            regs <= next_regs;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign req_ready_out = (regs.state == asmc_pkg::ST_IDLE); // Handshake may be combinational
    assign rdata_out = regs.rdata;
    assign rdata_valid_out = regs.rvalid;
    assign wdone_out = regs.wdone;
    assign mem_addr_out = regs.addr;
    assign mem_chip_sel_n_out = regs.chip_sel_n;
    assign mem_write_strobe_n_out = regs.write_strobe_n;
    assign mem_out_gate_n_out = regs.out_gate_n;
    assign mem_data_out = regs.wdata;
    assign mem_data_oe_out = regs.data_oe;

endmodule
`default_nettype wire

/* tb/asmc_host_sva.sv */
// Checker of the memory pin protocol at the host controller ports
`timescale 1ns/10ps
`default_nettype none
module asmc_host_sva (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic req_ready_out,
    input wire logic rdata_valid_out,
    input wire logic [asmc_pkg::ADDR_WIDTH-1:0] mem_addr_out,
    input wire logic mem_chip_sel_n_out,
    input wire logic mem_write_strobe_n_out,
    input wire logic mem_out_gate_n_out,
    input wire logic mem_data_oe_out
);
    // ----------------------------------------------------------------
    // Short aliases of the strobes
    // ----------------------------------------------------------------
    wire logic cs_n; // Select
    wire logic we_n; // Write strobe
    wire logic oe_n; // Output gate
    assign cs_n = mem_chip_sel_n_out;
    assign we_n = mem_write_strobe_n_out;
    assign oe_n = mem_out_gate_n_out;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    // ----------------------------------------------------------------
    // Pin protocol
    // ----------------------------------------------------------------
    AST_READ_STROBE_HIGH: assert property (!cs_n && $past(!cs_n) && $past(we_n) |-> we_n)
        else $error("strobe fell inside a select");
    AST_ADDR_BEFORE_SEL: assert property ($fell(cs_n) |-> $stable(mem_addr_out))
        else $error("address moved as select fell");
    AST_ADDR_CHANGE: assert property (!$stable(mem_addr_out) |-> cs_n && $past(cs_n))
        else $error("address moved while selected");
    AST_STROBE_ENDS_FIRST: assert property ($rose(cs_n) |-> we_n)
        else $error("select rose before strobe");
    AST_NO_CONTENTION: assert property (mem_data_oe_out |-> cs_n || !we_n || oe_n)
        else $error("host drives while memory drives");
    AST_SEL_WITH_STROBE: assert property ($fell(we_n) |-> $fell(cs_n))
        else $error("strobe fell apart from select");
    AST_PULSE_GATE_LOW: assert property ($fell(we_n) && !oe_n |-> !we_n [*3])
        else $error("short pulse with gate low");
    AST_PULSE_GATE_HIGH: assert property ($fell(we_n) |-> !we_n [*2])
        else $error("write pulse below minimum");
    AST_READ_DATA_TIME: assert property ($fell(oe_n) && we_n |-> !oe_n [*5] ##1 rdata_valid_out)
        else $error("read data not on time");
    AST_IDLE_PINS_HIGH: assert property (req_ready_out |-> cs_n && we_n)
        else $error("strobes low while idle");
endmodule
bind asmc_host asmc_host_sva asmc_host_sva_i (.clk_sys_in, .reset_in, .req_ready_out, .rdata_valid_out,
    .mem_addr_out, .mem_chip_sel_n_out, .mem_write_strobe_n_out, .mem_out_gate_n_out, .mem_data_oe_out);
`default_nettype wire

/* tb/asmc_mem_model.sv */
// Behavioural model of the byte-wide asynchronous static memory
`timescale 1ns/10ps
`default_nettype none
module asmc_mem_model #(
    parameter int ACCESS_NS = 12 // Gate access delay, raise it to model a slow part
) (
    input wire logic [18:0] addr_in,
    input wire logic chip_sel_n_in,
    input wire logic write_strobe_n_in,
    input wire logic out_gate_n_in,
    input wire logic [7:0] host_data_in,
    input wire logic host_oe_in,
    output logic [7:0] bus_out,
    output logic standby_out
);
    // ----------------------------------------------------------------
    // Storage and strobes
    // ----------------------------------------------------------------
    logic [7:0] bank [4][131072]; // Four equal banks picked by the top bits
    wire logic [7:0] word; // Word at the current address
    wire logic wr; // Select and strobe overlap
    wire logic drive; // Memory drives the data pins
    assign word = bank[addr_in[18:17]][addr_in[16:0]];
    assign wr = !chip_sel_n_in && !write_strobe_n_in;
    // Store at the end of the overlap, no clock involved
    // An undriven bus stores garbage, so a write without host data shows up on read back
    always @(negedge wr) bank[addr_in[18:17]][addr_in[16:0]] = host_oe_in ? host_data_in : 'x;
    // Inertial delay: also floats within the deselect time
    assign #(ACCESS_NS) drive = !chip_sel_n_in && !out_gate_n_in && write_strobe_n_in;
    assign #(25) standby_out = chip_sel_n_in;
    // Wire level; a released bus shows the inverse so stale data never passes
    always_comb begin
        if (host_oe_in && drive) bus_out = 'x;
        else if (host_oe_in) bus_out = host_data_in;
        else if (drive) bus_out = word;
        else bus_out = ~word;
    end
endmodule
`default_nettype wire

/* tb/asmc_host_bench.sv */
// Self-checking bench of the static memory host controller
`timescale 1ns/10ps
`default_nettype none
module asmc_host_bench;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic req_valid_in = 1'b0, req_write_in = 1'b0, req_gate_low_in = 1'b0;
    logic [18:0] req_addr_in = 19'h0_0000;
    logic [7:0] req_wdata_in = 8'h00;
    logic req_ready_out, rdata_valid_out, wdone_out, cs_n, we_n, oe_n, data_oe;
    logic [7:0] rdata_out, data_out, data_in;
    logic [18:0] addr;
    int fail_count = 0;
    int total_checks = 0;
    // Edges from take to pulse: setup, pulse or cycle time, then hold or the two sync flops
    localparam int WR_LAT = asmc_pkg::SETUP_CYCLES + asmc_pkg::PULSE_GATE_HIGH_CYCLES + asmc_pkg::HOLD_CYCLES;
    localparam int GL_LAT = asmc_pkg::SETUP_CYCLES + asmc_pkg::PULSE_GATE_LOW_CYCLES + asmc_pkg::HOLD_CYCLES;
    localparam int RD_LAT = asmc_pkg::SETUP_CYCLES + asmc_pkg::CYCLE_CYCLES + 2;
    logic [18:0] addrs [4] = '{19'h0_0000, 19'h2_0001, 19'h4_FFFE, 19'h7_FFFF}; // One per bank
    always #5 clk_sys_in = ~clk_sys_in;
    asmc_host asmc_host_i (.clk_sys_in, .reset_in, .req_valid_in, .req_write_in, .req_gate_low_in,
        .req_addr_in, .req_wdata_in, .req_ready_out, .rdata_out, .rdata_valid_out, .wdone_out,
        .mem_addr_out(addr), .mem_chip_sel_n_out(cs_n), .mem_write_strobe_n_out(we_n),
        .mem_out_gate_n_out(oe_n), .mem_data_out(data_out), .mem_data_oe_out(data_oe), .mem_data_in(data_in));
    asmc_mem_model asmc_mem_model_i (.addr_in(addr), .chip_sel_n_in(cs_n), .write_strobe_n_in(we_n),
        .out_gate_n_in(oe_n), .host_data_in(data_out), .host_oe_in(data_oe), .bus_out(data_in), .standby_out());
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("ERROR %0t got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    // One request; lat is the edge count from take to the done pulse, or to the read valid pulse for a read
    task automatic access(input logic w, input logic g, input logic [18:0] a, input logic [7:0] d, output int lat);
        int i;
        lat = 0;
        for (i = 0; i < 20 && req_ready_out !== 1'b1; i++) @(negedge clk_sys_in);
        req_valid_in = 1'b1;
        req_write_in = w;
        req_gate_low_in = g;
        req_addr_in = a;
        req_wdata_in = d;
        @(negedge clk_sys_in);
        req_valid_in = 1'b0;
        for (i = 1; i <= 12 && lat == 0; i++) begin
            @(negedge clk_sys_in);
            if ((w ? wdone_out : rdata_valid_out) === 1'b1) lat = i;
        end
    endtask
    task automatic stop_test;
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk({3'b000, cs_n, we_n, oe_n, data_oe, req_ready_out}, 8'h1D);
    endtask
    // Fill one word per bank, boundaries included, then read all back
    task automatic t_banks;
        int lat;
        for (int k = 0; k < 4; k++) begin
            access(1'b1, 1'b0, addrs[k], 8'hA0 + 8'(k), lat);
            chk(8'(lat), 8'(WR_LAT));
        end
        for (int k = 0; k < 4; k++) begin
            access(1'b0, 1'b0, addrs[k], 8'h00, lat);
            chk(8'(lat), 8'(RD_LAT));
            chk(rdata_out, 8'hA0 + 8'(k));
        end
    endtask
    // Gate held low through the write, then read at once
    task automatic t_gate_low;
        int lat;
        access(1'b1, 1'b1, 19'h2_AAAA, 8'h5A, lat);
        chk(8'(lat), 8'(GL_LAT));
        access(1'b0, 1'b0, 19'h2_AAAA, 8'h00, lat);
        chk(rdata_out, 8'h5A);
    endtask
    // A request while busy must leave the memory untouched
    task automatic t_refuse;
        int lat;
        access(1'b1, 1'b0, 19'h1_2345, 8'h3C, lat);
        chk({7'h00, req_ready_out}, 8'h00);
        req_valid_in = 1'b1;
        req_wdata_in = 8'hC3;
        @(negedge clk_sys_in);
        req_valid_in = 1'b0;
        access(1'b0, 1'b0, 19'h1_2345, 8'h00, lat);
        chk(rdata_out, 8'h3C);
    endtask
    // Reset in the middle of a write raises the strobes at once, then a read still works
    task automatic t_mid_reset;
        int lat;
        for (int i = 0; i < 20 && req_ready_out !== 1'b1; i++) @(negedge clk_sys_in);
        req_valid_in = 1'b1;
        req_write_in = 1'b1;
        req_gate_low_in = 1'b0;
        req_addr_in = 19'h0_0055;
        req_wdata_in = 8'h99;
        @(negedge clk_sys_in);
        req_valid_in = 1'b0;
        @(negedge clk_sys_in);
        chk({7'h00, we_n}, 8'h00);
        reset_in = 1'b1;
        #1;
        chk({3'b000, cs_n, we_n, oe_n, data_oe, req_ready_out}, 8'h1D);
        @(negedge clk_sys_in);
        reset_in = 1'b0;
        access(1'b0, 1'b0, addrs[3], 8'h00, lat);
        chk(8'(lat), 8'(RD_LAT));
        chk(rdata_out, 8'hA3);
    endtask
    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(negedge clk_sys_in);
        reset_in = 1'b0;
        t_reset();
        t_banks();
        t_gate_low();
        t_refuse();
        t_mid_reset();
        stop_test();
    end
    initial begin
        #(5000 * 10);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
